// [stpfc_defs.svh]
`ifndef STPFC_DEFS_SVH
`define STPFC_DEFS_SVH

// ==========================================================
// Register offsets
`define STPFC_OFS_CTRL 8'h00
`define STPFC_OFS_STATUS 8'h04
`define STPFC_OFS_MASK 8'h08
`define STPFC_OFS_STATE 8'h0c

// ==========================================================
// Bus responses
`define STPFC_RESP_OKAY 2'b00
`define STPFC_RESP_SLVERR 2'b10

// ==========================================================
// Timing
`define STPFC_CLK_PERIOD_NS 25
`define STPFC_OCP_QUAL_NS 4000
`define STPFC_OCP_QUAL_CYC ((`STPFC_OCP_QUAL_NS + `STPFC_CLK_PERIOD_NS - 1) / `STPFC_CLK_PERIOD_NS)

// ==========================================================
// Reset values
`define STPFC_CTRL_RST 16'(`STPFC_OCP_QUAL_CYC)
`define STPFC_MASK_RST 4'h0
`define STPFC_HOME_INDEX 7'h00

// ==========================================================
// Event bits of STATUS and MASK
`define STPFC_EVT_OCP 0
`define STPFC_EVT_THERM 1
`define STPFC_EVT_UV 2
`define STPFC_EVT_STEP_IGN 3

// ==========================================================
// Bits of STATE
`define STPFC_ST_INDEX 0
`define STPFC_ST_BRIDGE 8
`define STPFC_ST_FAULT 9
`define STPFC_ST_SLEEP 10
`define STPFC_ST_OCP 11
`define STPFC_ST_THERM 12
`define STPFC_ST_UV 13

`endif

// [stpfc_pkg.sv]
package stpfc_pkg;

  // ==========================================================
  // Bridge drive state
  typedef enum logic [1:0] {
    DRV_OFF = 2'b00,
    DRV_RUN = 2'b01,
    DRV_TRIP = 2'b10,
    DRV_SLEEP = 2'b11
  } stpfc_drv_e;

  typedef logic [1:0] stpfc_resp_t;
  typedef logic [3:0] stpfc_evt_t;

endpackage

// [stpfc_prot_if.sv]
`timescale 1ns/10ps
`default_nettype none

interface stpfc_prot_if;
  logic [15:0] qual_cycles;
  logic clear_ocp;
  logic hold;
  logic ocp_latched;
  logic thermal_active;
  logic uv_active;
  logic ocp_event;
  logic thermal_event;
  logic uv_event;

  modport prot (
    input qual_cycles, clear_ocp, hold,
    output ocp_latched, thermal_active, uv_active, ocp_event, thermal_event, uv_event
  );
  modport ctrl (
    output qual_cycles, clear_ocp, hold,
    input ocp_latched, thermal_active, uv_active, ocp_event, thermal_event, uv_event
  );
endinterface

`default_nettype wire

// [stpfc_protect.sv]
`timescale 1ns/10ps
`default_nettype none

module stpfc_protect (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Raw analog comparator flags
  input wire logic ocp_pin,
  input wire logic thermal_pin,
  input wire logic uv_pin,
  // Toward the controller
  stpfc_prot_if.prot pif
);

  // ==========================================================
  // Synchronisers, overcurrent qualifier and latch
  logic [2:0] meta_reg, meta_next;
  logic [2:0] sync_reg, sync_next;
  logic [2:0] prev_reg, prev_next;
  logic [15:0] cnt_reg, cnt_next;
  logic ocp_reg, ocp_next;

  always_comb begin
    meta_next = {uv_pin, thermal_pin, ocp_pin};
    sync_next = meta_reg;
    prev_next = {sync_reg[2], sync_reg[1], ocp_reg};
    cnt_next = cnt_reg;
    ocp_next = ocp_reg;
    if (pif.clear_ocp || sync_reg[2]) begin
      cnt_next = 16'h0000;
      ocp_next = 1'b0;
    end else if (!sync_reg[0]) begin
      cnt_next = 16'h0000;
    end else if (!ocp_reg && !pif.hold) begin
      // Any FET flag feeds one shared comparator input
      if (cnt_reg >= pif.qual_cycles) begin
        ocp_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 3'h0;
      sync_reg <= 3'h0;
      prev_reg <= 3'h0;
      cnt_reg <= 16'h0000;
      ocp_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
      cnt_reg <= cnt_next;
      ocp_reg <= ocp_next;
    end
  end

  assign pif.ocp_latched = ocp_reg;
  assign pif.thermal_active = sync_reg[1];
  assign pif.uv_active = sync_reg[2];
  assign pif.ocp_event = ocp_reg & ~prev_reg[0];
  assign pif.thermal_event = sync_reg[1] & ~prev_reg[1];
  assign pif.uv_event = sync_reg[2] & ~prev_reg[2];

endmodule // stpfc_protect

`default_nettype wire

// [stpfc_ctrl.sv]
// Functional notes
// - A low chip reset clears internal logic and puts the step index at home.
// - A low chip reset keeps both bridges off for as long as it is held.
// - Step edges seen during chip reset never move the index.
// - With enable low the bridges drive and each rising step edge moves the index.
// - With enable high the bridges are off, outputs float and step edges are ignored.
// - Sleep low turns off bridges, charge pump, aux regulator and internal clocks.
// - In sleep every input except the sleep pin is ignored; here the thermal and supply lockout flags still act in sleep.
// - Overcurrent held past the qualification time turns all FETs off and pulls fault low.
// - An overcurrent trip stays latched until chip reset or supply loss.
// - High-side and low-side overcurrent of any kind cause the same trip.
// - Over-temperature turns all FETs off and pulls fault low, then recovers by itself.
// - Supply lockout disables everything and holds logic in reset until it clears.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`include "stpfc_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module stpfc_ctrl
  import stpfc_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int INDEX_W = 7
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Motion controller pins
  input wire logic STEP,
  input wire logic DIR,
  input wire logic CHIP_RESET_LOW,
  input wire logic DRIVER_ENABLE_LOW,
  input wire logic SLEEP_REQUEST_LOW,
  // Analog protection flags
  input wire logic OVERCURRENT_TRIP,
  input wire logic THERMAL_TRIP,
  input wire logic SUPPLY_LOW_LOCKOUT,
  // Power stage controls
  output logic BRIDGE_EN,
  output logic OUT_HIZ,
  output logic CHARGE_PUMP_EN,
  output logic AUX_REGULATOR_OUT_EN,
  output logic CLOCKS_RUN,
  output logic [INDEX_W-1:0] STEP_INDEX,
  // Open-drain fault pin
  output logic FAULT_FLAG_LOW_O,
  output logic FAULT_FLAG_LOW_OE,
  // Interrupt
  output logic IRQ,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  localparam int PIN_N = 5;
  localparam int P_STEP = 0;
  localparam int P_DIR = 1;
  localparam int P_RST = 2;
  localparam int P_EN = 3;
  localparam int P_SLP = 4;

  // ==========================================================
  // Pin synchronisers
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] pin_meta_reg;
  logic [PIN_N-1:0] pin_sync_reg;

  assign pin_raw = {SLEEP_REQUEST_LOW, DRIVER_ENABLE_LOW, CHIP_RESET_LOW, DIR, STEP};

  // Pins come up low, so reset and sleep read asserted
  for (genvar g = 0; g < PIN_N; g++) begin : g_pin
    always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
        pin_meta_reg[g] <= 1'b0;
        pin_sync_reg[g] <= 1'b0;
      end else begin
        pin_meta_reg[g] <= pin_raw[g];
        pin_sync_reg[g] <= pin_meta_reg[g];
      end
    end
  end

  // ==========================================================
  // Protection block
  stpfc_prot_if pif ();
  logic [15:0] ctrl_reg, ctrl_next;
  logic in_reset;
  logic asleep;

  assign in_reset = (~pin_sync_reg[P_RST] & ~asleep) | pif.uv_active;
  assign asleep = ~pin_sync_reg[P_SLP] & ~pif.uv_active;
  assign pif.qual_cycles = ctrl_reg;
  assign pif.clear_ocp = ~pin_sync_reg[P_RST] & ~asleep;
  assign pif.hold = asleep;

  stpfc_protect u_protect (
    .clk(CLK),
    .rst_n(RST_N),
    .ocp_pin(OVERCURRENT_TRIP),
    .thermal_pin(THERMAL_TRIP),
    .uv_pin(SUPPLY_LOW_LOCKOUT),
    .pif(pif.prot)
  );

  // ==========================================================
  // Indexer
  logic step_prev_reg, step_prev_next;
  logic [INDEX_W-1:0] index_reg, index_next;
  logic step_rise;
  logic step_ok;
  logic step_ign;

  // Edge history runs in sleep too, so a level change there is no edge at wake
  assign step_rise = pin_sync_reg[P_STEP] & ~step_prev_reg;
  assign step_ok = ~in_reset & ~asleep & ~pin_sync_reg[P_EN];
  assign step_ign = step_rise & ~step_ok & ~asleep;

  always_comb begin
    step_prev_next = pin_sync_reg[P_STEP];
    index_next = index_reg;
    if (in_reset) begin
      index_next = INDEX_W'(`STPFC_HOME_INDEX);
    end else if (asleep) begin
      index_next = index_reg;
    end else if (step_rise && step_ok) begin
      if (pin_sync_reg[P_DIR]) begin
        index_next = index_reg + INDEX_W'(1);
      end else begin
        index_next = index_reg - INDEX_W'(1);
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      step_prev_reg <= 1'b0;
      index_reg <= INDEX_W'(`STPFC_HOME_INDEX);
    end else begin
      step_prev_reg <= step_prev_next;
      index_reg <= index_next;
    end
  end

  // ==========================================================
  // Power stage state
  stpfc_drv_e drv_reg, drv_next;
  logic fault_reg, fault_next;

  always_comb begin
    if (pif.uv_active || in_reset) begin
      drv_next = DRV_OFF;
    end else if (asleep) begin
      drv_next = DRV_SLEEP;
    end else if (pif.ocp_latched || pif.thermal_active) begin
      drv_next = DRV_TRIP;
    end else if (pin_sync_reg[P_EN]) begin
      drv_next = DRV_OFF;
    end else begin
      drv_next = DRV_RUN;
    end
    // Lockout releases the pin along with everything else
    fault_next = (pif.ocp_latched | pif.thermal_active) & ~pif.uv_active;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      drv_reg <= DRV_OFF;
      fault_reg <= 1'b0;
    end else begin
      drv_reg <= drv_next;
      fault_reg <= fault_next;
    end
  end

  assign BRIDGE_EN = (drv_reg == DRV_RUN);
  assign OUT_HIZ = (drv_reg != DRV_RUN);
  assign CHARGE_PUMP_EN = (drv_reg != DRV_SLEEP) & ~pif.uv_active;
  assign AUX_REGULATOR_OUT_EN = (drv_reg != DRV_SLEEP) & ~pif.uv_active;
  assign CLOCKS_RUN = (drv_reg != DRV_SLEEP) & ~pif.uv_active;
  assign STEP_INDEX = index_reg;
  assign FAULT_FLAG_LOW_O = 1'b0;
  assign FAULT_FLAG_LOW_OE = fault_reg;

  // ==========================================================
  // Register file: write path
  logic aw_held_reg, aw_held_next;
  logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic w_held_reg, w_held_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next;
  stpfc_resp_t bresp_reg, bresp_next;
  stpfc_evt_t mask_reg, mask_next;
  logic do_write;

  assign S_AXI_AWREADY = ~aw_held_reg & ~bvalid_reg;
  assign S_AXI_WREADY = ~w_held_reg & ~bvalid_reg;
  assign do_write = aw_held_reg & w_held_reg;

  always_comb begin
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next = w_held_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held_next = 1'b1;
      aw_addr_next = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held_next = 1'b1;
      w_data_next = S_AXI_WDATA;
      w_strb_next = S_AXI_WSTRB;
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = `STPFC_RESP_OKAY;
      unique case (aw_addr_reg)
        `STPFC_OFS_CTRL: begin
          if (w_strb_reg[0]) ctrl_next[7:0] = w_data_reg[7:0];
          if (w_strb_reg[1]) ctrl_next[15:8] = w_data_reg[15:8];
        end
        `STPFC_OFS_MASK: begin
          if (w_strb_reg[0]) mask_next = w_data_reg[3:0];
        end
        // Status clears on read only; state is read-only
        `STPFC_OFS_STATUS, `STPFC_OFS_STATE: begin
        end
        default: bresp_next = `STPFC_RESP_SLVERR;
      endcase
    end else if (bvalid_reg && S_AXI_BREADY) begin
      bvalid_next = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `STPFC_RESP_OKAY;
      ctrl_reg <= `STPFC_CTRL_RST;
      mask_reg <= `STPFC_MASK_RST;
    end else begin
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
      w_held_reg <= w_held_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      ctrl_reg <= ctrl_next;
      mask_reg <= mask_next;
    end
  end

  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;

  // ==========================================================
  // Register file: read path and sticky events
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  stpfc_resp_t rresp_reg, rresp_next;
  stpfc_evt_t status_reg, status_next;
  stpfc_evt_t events;
  stpfc_evt_t rd_clear;
  logic [31:0] state_word;

  always_comb begin
    events = '0;
    events[`STPFC_EVT_OCP] = pif.ocp_event;
    events[`STPFC_EVT_THERM] = pif.thermal_event;
    events[`STPFC_EVT_UV] = pif.uv_event;
    events[`STPFC_EVT_STEP_IGN] = step_ign;
    state_word = 32'h0000_0000;
    state_word[`STPFC_ST_INDEX +: INDEX_W] = index_reg;
    state_word[`STPFC_ST_BRIDGE] = (drv_reg == DRV_RUN);
    state_word[`STPFC_ST_FAULT] = fault_reg;
    state_word[`STPFC_ST_SLEEP] = (drv_reg == DRV_SLEEP);
    state_word[`STPFC_ST_OCP] = pif.ocp_latched;
    state_word[`STPFC_ST_THERM] = pif.thermal_active;
    state_word[`STPFC_ST_UV] = pif.uv_active;
  end

  assign S_AXI_ARREADY = ~rvalid_reg;

  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    rd_clear = '0;
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_next = 1'b1;
      rresp_next = `STPFC_RESP_OKAY;
      unique case (S_AXI_ARADDR)
        `STPFC_OFS_CTRL: rdata_next = {16'h0000, ctrl_reg};
        `STPFC_OFS_STATUS: begin
          rdata_next = {28'h0000000, status_reg};
          rd_clear = status_reg;
        end
        `STPFC_OFS_MASK: rdata_next = {28'h0000000, mask_reg};
        `STPFC_OFS_STATE: rdata_next = state_word;
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = `STPFC_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_next = 1'b0;
    end
    // A new event in the clearing cycle survives the clear
    status_next = (status_reg & ~rd_clear) | events;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `STPFC_RESP_OKAY;
      status_reg <= 4'h0;
    end else begin
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      status_reg <= status_next;
    end
  end

  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;
  assign IRQ = |(status_reg & mask_reg);

endmodule // stpfc_ctrl

`default_nettype wire

// [stpfc_ctrl_checker.sv]
`timescale 1ns/10ps
`default_nettype none

module stpfc_ctrl_checker #(
  parameter int ADDR_W = 8,
  parameter int INDEX_W = 7
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Pins
  input wire logic STEP,
  input wire logic DIR,
  input wire logic CHIP_RESET_LOW,
  input wire logic DRIVER_ENABLE_LOW,
  input wire logic SLEEP_REQUEST_LOW,
  input wire logic OVERCURRENT_TRIP,
  input wire logic THERMAL_TRIP,
  input wire logic SUPPLY_LOW_LOCKOUT,
  // Power stage
  input wire logic BRIDGE_EN,
  input wire logic OUT_HIZ,
  input wire logic CHARGE_PUMP_EN,
  input wire logic AUX_REGULATOR_OUT_EN,
  input wire logic CLOCKS_RUN,
  input wire logic [INDEX_W-1:0] STEP_INDEX,
  input wire logic FAULT_FLAG_LOW_OE
);
  logic dir_reg;
  logic run_ok;
  logic quiet_ok;

  always_ff @(posedge CLK) dir_reg <= DIR;
  // Direction must not move across the edge, or the expected sign is ambiguous
  assign run_ok = CHIP_RESET_LOW && !DRIVER_ENABLE_LOW && SLEEP_REQUEST_LOW
                  && !SUPPLY_LOW_LOCKOUT && (DIR == dir_reg);
  assign quiet_ok = CHIP_RESET_LOW && !SUPPLY_LOW_LOCKOUT && !THERMAL_TRIP;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // ==========================================================
  // Sequences
  sequence s_pulse;
    run_ok[*2] ##1 (run_ok && $rose(STEP)) ##1 (run_ok && STEP)[*3] ##1 run_ok;
  endsequence
  sequence s_latched;
    (quiet_ok && FAULT_FLAG_LOW_OE)[*6];
  endsequence

  // ==========================================================
  // Assertions
  a_step_moves_index: assert property (
    s_pulse |-> STEP_INDEX == INDEX_W'(DIR ? $past(STEP_INDEX, 5) + 1 : $past(STEP_INDEX, 5) - 1))
    else $error("step edge did not move the index by one");
  a_reset_home_off: assert property (
    (!CHIP_RESET_LOW && SLEEP_REQUEST_LOW)[*4]
      |-> (STEP_INDEX == '0 && !BRIDGE_EN) ##1 STEP_INDEX == '0)
    else $error("chip reset did not home index and stop bridges");
  a_disable_float: assert property (
    (DRIVER_ENABLE_LOW && CHIP_RESET_LOW && !SUPPLY_LOW_LOCKOUT)[*6]
      |-> (!BRIDGE_EN && OUT_HIZ) ##1 $stable(STEP_INDEX))
    else $error("disabled driver still drives or steps");
  a_sleep_power_off: assert property (
    (!SLEEP_REQUEST_LOW)[*4]
      |-> !BRIDGE_EN && !CHARGE_PUMP_EN && !AUX_REGULATOR_OUT_EN && !CLOCKS_RUN)
    else $error("sleep left a supply or bridge running");
  a_sleep_freeze: assert property (
    (!SLEEP_REQUEST_LOW && CHIP_RESET_LOW && !SUPPLY_LOW_LOCKOUT)[*4] |=> $stable(STEP_INDEX))
    else $error("index moved during sleep");
  a_fault_bridge_off: assert property (
    FAULT_FLAG_LOW_OE[*2] |-> !BRIDGE_EN)
    else $error("bridges on while fault is flagged");
  a_latch_holds: assert property (
    s_latched |=> FAULT_FLAG_LOW_OE)
    else $error("overcurrent latch released by itself");
  a_no_false_trip: assert property (
    (!OVERCURRENT_TRIP && !THERMAL_TRIP && !FAULT_FLAG_LOW_OE)[*5] |=> !FAULT_FLAG_LOW_OE)
    else $error("fault raised without a cause");
  a_lockout_off: assert property (
    SUPPLY_LOW_LOCKOUT[*4] |-> STEP_INDEX == '0 && !BRIDGE_EN && !CHARGE_PUMP_EN
      && !CLOCKS_RUN && !FAULT_FLAG_LOW_OE)
    else $error("lockout left logic active");
endmodule // stpfc_ctrl_checker

bind stpfc_ctrl stpfc_ctrl_checker #(.ADDR_W(ADDR_W), .INDEX_W(INDEX_W)) i_chk (
  .CLK, .RST_N, .STEP, .DIR, .CHIP_RESET_LOW, .DRIVER_ENABLE_LOW, .SLEEP_REQUEST_LOW,
  .OVERCURRENT_TRIP, .THERMAL_TRIP, .SUPPLY_LOW_LOCKOUT, .BRIDGE_EN, .OUT_HIZ,
  .CHARGE_PUMP_EN, .AUX_REGULATOR_OUT_EN, .CLOCKS_RUN, .STEP_INDEX, .FAULT_FLAG_LOW_OE);

`default_nettype wire

// [stpfc_motion_model.sv]
`timescale 1ns/10ps
`default_nettype none

module stpfc_motion_model #(
  parameter int WAKE_CYC = 40000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Commands
  input wire logic sleep_low,
  input wire logic start,
  input wire logic dir_in,
  input wire logic rude,
  // Pins toward the driver
  output logic step,
  output logic dir,
  output logic busy
);
  logic [3:0] ph_reg;
  int wake_reg;

  // ==========================================================
  // Step sequencer: direction settles two cycles ahead, pulse four high, seven low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_reg <= 4'h0;
      step <= 1'b0;
      dir <= 1'b0;
      // Power-up is no wake from sleep, so no settling wait
      wake_reg <= WAKE_CYC;
    end else begin
      wake_reg <= !sleep_low ? 0 : (wake_reg < WAKE_CYC ? wake_reg + 1 : wake_reg);
      if (ph_reg == 4'hc) ph_reg <= 4'h0;
      else if (ph_reg != 4'h0) ph_reg <= ph_reg + 4'h1;
      else if (start && (rude || wake_reg >= WAKE_CYC)) begin
        ph_reg <= 4'h1;
        dir <= dir_in;
      end
      step <= (ph_reg >= 4'h2) && (ph_reg < 4'h6);
    end
  end
  assign busy = (ph_reg != 4'h0);
endmodule // stpfc_motion_model

`default_nettype wire

// [tb.sv]
`include "stpfc_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module tb;
  // Settling wait after wake, 1 ms at 25 ns
  localparam int WAKE = 40000;
  logic CLK, RST_N = 1'b0, crl = 1'b1, enl = 1'b0, slp = 1'b1, overcurrent_trip = 1'b0, thm = 1'b0;
  logic uvl = 1'b0, start = 1'b0, dirq = 1'b0, rude = 1'b0, up, step, dir, busy;
  logic [7:0] aw = 8'h00, ar = 8'h00;
  logic [31:0] wd = 32'h0, d, rdata;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [1:0] r, bresp, rresp;
  logic [6:0] idx, exp_idx;
  logic bri, hiz, cpe, aux, clk_run, irq, f_o, f_oe, awrdy, wrdy, bv, arrdy, rv;
  wire fault_n = f_oe ? f_o : 1'b1;
  int n_errors = 0, comparisons = 0, cycles = 0;

  stpfc_ctrl #(.ADDR_W(8), .INDEX_W(7)) i_dut (
    .CLK(CLK), .RST_N(RST_N), .STEP(step), .DIR(dir), .CHIP_RESET_LOW(crl),
    .DRIVER_ENABLE_LOW(enl), .SLEEP_REQUEST_LOW(slp), .OVERCURRENT_TRIP(overcurrent_trip),
    .THERMAL_TRIP(thm), .SUPPLY_LOW_LOCKOUT(uvl), .BRIDGE_EN(bri), .OUT_HIZ(hiz),
    .CHARGE_PUMP_EN(cpe), .AUX_REGULATOR_OUT_EN(aux), .CLOCKS_RUN(clk_run), .STEP_INDEX(idx),
    .FAULT_FLAG_LOW_O(f_o), .FAULT_FLAG_LOW_OE(f_oe), .IRQ(irq),
    .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rr));
  stpfc_motion_model #(.WAKE_CYC(WAKE)) i_ctl (.clk(CLK), .rst_n(RST_N), .sleep_low(slp),
    .start(start), .dir_in(dirq), .rude(rude), .step(step), .dir(dir), .busy(busy));

  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  // ==========================================================
  // Helpers
  function automatic logic [6:0] nxt(input logic [6:0] i, input logic inc);
    return inc ? i + 7'h01 : i - 7'h01;
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic summarize;
    if (n_errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Lands just after the edge so the design's updates are settled
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tk;
    aw <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    tk = 1'b0;
    while (!tk) begin
      @(negedge CLK);
      ta = awv & awrdy;
      tw = wv & wrdy;
      tk = bv;
      r = bresp;
      @(posedge CLK);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tk) br <= 1'b0;
    end
    cyc(1);
  endtask

  task automatic rd(input logic [7:0] a);
    logic ta, tk;
    ar <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    tk = 1'b0;
    while (!tk) begin
      @(negedge CLK);
      ta = arv & arrdy;
      tk = rv;
      d = rdata;
      r = rresp;
      @(posedge CLK);
      if (ta) arv <= 1'b0;
      if (tk) rr <= 1'b0;
    end
    cyc(1);
  endtask

  task automatic step1(input logic inc);
    start <= 1'b1;
    dirq <= inc;
    do @(negedge CLK); while (!busy);
    @(posedge CLK);
    start <= 1'b0;
    do @(negedge CLK); while (busy);
    cyc(4);
  endtask

  always @(posedge CLK) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors++;
      summarize();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32));
    repeat (3) @(posedge CLK);
    RST_N <= 1'b1;
    cyc(4);
    rd(`STPFC_OFS_CTRL);
    chk("ctrl_reset", d, 32'(`STPFC_CTRL_RST));
    rd(`STPFC_OFS_MASK);
    chk("mask_reset", d, 32'h0);
    rd(8'h40);
    chk("unmapped_resp", 32'(r), 32'(`STPFC_RESP_SLVERR));
    exp_idx = `STPFC_HOME_INDEX;
    // Wrap below home first, then a random walk
    step1(1'b0);
    exp_idx = nxt(exp_idx, 1'b0);
    repeat (6) begin
      up = 1'($urandom % 2);
      step1(up);
      exp_idx = nxt(exp_idx, up);
    end
    chk("index_run", 32'(idx), 32'(exp_idx));
    chk("bridge_run", 32'({bri, hiz}), 32'h2);
    enl <= 1'b1;
    wr(`STPFC_OFS_MASK, 32'h0);
    chk("write_resp", 32'(r), 32'(`STPFC_RESP_OKAY));
    step1(1'b1);
    chk("index_disabled", 32'(idx), 32'(exp_idx));
    chk("bridge_disabled", 32'({bri, hiz, irq}), 32'h2);
    wr(`STPFC_OFS_MASK, 32'h8);
    chk("irq_unmasked", 32'(irq), 32'h1);
    rd(`STPFC_OFS_STATUS);
    chk("status_ignored", d & 32'h8, 32'h8);
    chk("irq_cleared", 32'(irq), 32'h0);
    enl <= 1'b0;
    crl <= 1'b0;
    step1(1'b1);
    chk("chip_reset", 32'({idx, bri}), 32'h0);
    crl <= 1'b1;
    exp_idx = `STPFC_HOME_INDEX;
    slp <= 1'b0;
    cyc(4);
    chk("sleep_power", 32'({bri, cpe, aux, clk_run}), 32'h0);
    rude <= 1'b1;
    enl <= 1'b1;
    step1(1'b1);
    chk("sleep_index", 32'(idx), 32'(exp_idx));
    rude <= 1'b0;
    enl <= 1'b0;
    slp <= 1'b1;
    step1(1'b1);
    exp_idx = nxt(exp_idx, 1'b1);
    chk("wake_step", 32'({idx, bri, cpe, aux, clk_run}), 32'({exp_idx, 4'hf}));
    wr(`STPFC_OFS_CTRL, 32'h2);
    overcurrent_trip <= 1'b1;
    cyc(2);
    overcurrent_trip <= 1'b0;
    cyc(6);
    chk("ocp_short", 32'(f_oe), 32'h0);
    overcurrent_trip <= 1'b1;
    cyc(3);
    overcurrent_trip <= 1'b0;
    cyc(6);
    chk("ocp_trip", 32'({f_oe, fault_n, bri}), 32'h4);
    cyc(30);
    chk("ocp_latched", 32'({f_oe, bri}), 32'h2);
    rd(`STPFC_OFS_STATUS);
    chk("status_ocp", d & 32'h1, 32'h1);
    crl <= 1'b0;
    cyc(4);
    crl <= 1'b1;
    cyc(5);
    chk("ocp_cleared", 32'({f_oe, bri}), 32'h1);
    thm <= 1'b1;
    cyc(5);
    chk("thermal_trip", 32'({f_oe, fault_n, bri}), 32'h4);
    thm <= 1'b0;
    cyc(5);
    chk("thermal_resume", 32'({f_oe, bri}), 32'h1);
    step1(1'b1);
    uvl <= 1'b1;
    cyc(5);
    chk("lockout", 32'({idx, bri, cpe, clk_run}), 32'h0);
    uvl <= 1'b0;
    cyc(5);
    chk("lockout_resume", 32'({bri, cpe, clk_run}), 32'h7);
    rd(`STPFC_OFS_STATUS);
    chk("status_events", d & 32'h6, 32'h6);
    rd(`STPFC_OFS_STATE);
    chk("state_word", d, 32'h1 << `STPFC_ST_BRIDGE);
    summarize();
  end
endmodule // tb

`default_nettype wire
